// ==== core/operand_decoder.sv ====
// Behaviour
// - Add object code: source byte before destination, except literal add (destination byte, then literal)
// - Register byte 0-255, escaped E selects working
// - Bit number is 3-bit field 0-7
// - Direct address is 16-bit unsigned
// - Far register location is 12 bits
// - Literal byte used directly as value
// - Working pairs only even registers 0-14
// - Register pairs only even locations 00-FE
// - Polarity is one bit, 0 or 1
// - Signed offset added to next instruction address
// - Signed index added to named register contents
// - Trap vector is 8-bit value
// - Add writes source plus destination to destination
`timescale 1ns/100ps
`default_nettype none

module operand_decoder
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Program memory byte stream
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_i,
    input wire logic [15:0] byte_addr_i,
    output logic byte_ready_o,
    // Register context
    input wire logic [7:0] rp_i,
    input wire logic [15:0] base_value_i,
    output logic [11:0] base_loc_o,
    // Decoded operands
    output logic ops_valid_o,
    output logic [7:0] opcode_o,
    output var opdec_pkg::fmt_t fmt_o,
    output var opdec_pkg::operand_t ops_o,
    // Register file port for the add
    output logic [11:0] src_loc_o,
    output logic [11:0] dst_loc_o,
    input wire logic [7:0] src_value_i,
    input wire logic [7:0] dst_value_i,
    output logic write_en_o,
    output logic [11:0] write_loc_o,
    output logic [7:0] write_data_o
);

    // ==========================================
    // State
    opdec_pkg::core_t q;
    opdec_pkg::core_t d;
    opdec_pkg::operand_t ext;

    // ==========================================
    // Opcode routing
    // Unknown opcodes map to no format and are skipped
    function automatic opdec_pkg::fmt_t opcode_fmt(input logic [7:0] opc);
        case (opc)
            opdec_pkg::OPC_ADD_REG: opcode_fmt = opdec_pkg::FMT_ADD_REG;
            opdec_pkg::OPC_ADD_LIT: opcode_fmt = opdec_pkg::FMT_ADD_LIT;
            opdec_pkg::OPC_ADD_FAR: opcode_fmt = opdec_pkg::FMT_ADD_FAR;
            opdec_pkg::OPC_JUMP: opcode_fmt = opdec_pkg::FMT_JUMP;
            opdec_pkg::OPC_BRANCH: opcode_fmt = opdec_pkg::FMT_BRANCH;
            opdec_pkg::OPC_TRAP: opcode_fmt = opdec_pkg::FMT_TRAP;
            opdec_pkg::OPC_BIT: opcode_fmt = opdec_pkg::FMT_BIT;
            opdec_pkg::OPC_INC_PAIR: opcode_fmt = opdec_pkg::FMT_PAIR;
            opdec_pkg::OPC_LOAD_INDEX: opcode_fmt = opdec_pkg::FMT_INDEX;
            default: opcode_fmt = opdec_pkg::FMT_NONE;
        endcase
    endfunction

    function automatic logic is_add(input opdec_pkg::fmt_t f);
        is_add = (f == opdec_pkg::FMT_ADD_REG) || (f == opdec_pkg::FMT_ADD_LIT)
            || (f == opdec_pkg::FMT_ADD_FAR);
    endfunction

    // ==========================================
    // Field extractor on the captured bytes
    operand_extract u_extract
    (
        .fmt_i(q.fmt),
        .bytes_i(q.bytes),
        .inst_addr_i(q.inst_addr),
        .rp_i(rp_i),
        .base_value_i(base_value_i),
        .ops_o(ext)
    );

    // ==========================================
    // Next state
    always_comb
    begin
        d = q;
        d.ops_valid = 1'b0;
        d.wr_en = 1'b0;
        case (q.st)
            opdec_pkg::ST_OPCODE:
            begin
                if (byte_valid_i)
                begin
                    d.opcode = byte_i;
                    d.fmt = opcode_fmt(byte_i);
                    d.inst_addr = byte_addr_i;
                    d.count = 2'd0;
                    d.bytes = '0;
                    if (d.fmt != opdec_pkg::FMT_NONE)
                        d.st = opdec_pkg::ST_OPERAND;
                end
            end
            opdec_pkg::ST_OPERAND:
            begin
                // Bytes land in fetch order, lowest slot first
                if (byte_valid_i)
                begin
                    d.bytes[q.count*8 +: 8] = byte_i;
                    d.count = q.count + 2'd1;
                    if (d.count == opdec_pkg::operand_bytes(q.fmt))
                        d.st = opdec_pkg::ST_DECODED;
                end
            end
            opdec_pkg::ST_DECODED:
            begin
                // Fields settle one cycle after the last byte
                d.ops = ext;
                d.ops_valid = 1'b1;
                if (is_add(q.fmt))
                    d.st = opdec_pkg::ST_ADD_READ;
                else
                    d.st = opdec_pkg::ST_OPCODE;
            end
            opdec_pkg::ST_ADD_READ:
            begin
                // Register file reads are combinational this cycle
                d.wr_loc = q.ops.dst_loc;
                if (q.fmt == opdec_pkg::FMT_ADD_LIT)
                    d.wr_data = dst_value_i + q.ops.literal_operand_byte;
                else
                    d.wr_data = dst_value_i + src_value_i;
                d.wr_en = 1'b1;
                d.st = opdec_pkg::ST_ADD_WRITE;
            end
            opdec_pkg::ST_ADD_WRITE:
                d.st = opdec_pkg::ST_OPCODE;
            default:
                d = opdec_pkg::CORE_RESET;
        endcase
    end

    // ==========================================
    // State register
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            q <= opdec_pkg::CORE_RESET;
        else
            q <= d;
    end

    // ==========================================
    // Outputs
    // No fetch while fields settle or the add runs
    assign byte_ready_o = (q.st == opdec_pkg::ST_OPCODE) || (q.st == opdec_pkg::ST_OPERAND);
    assign base_loc_o = {rp_i, q.bytes[3:0]};
    assign ops_valid_o = q.ops_valid;
    assign opcode_o = q.opcode;
    assign fmt_o = q.fmt;
    assign ops_o = q.ops;
    assign src_loc_o = q.ops.src_loc;
    assign dst_loc_o = q.ops.dst_loc;
    assign write_en_o = q.wr_en;
    assign write_loc_o = q.wr_loc;
    assign write_data_o = q.wr_data;

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    // Checks sleep while reset is held
    default disable iff (reset_i);

    // Add: first operand byte is the source
    chk_add_order: assert property (
        ops_valid_o && fmt_o == opdec_pkg::FMT_ADD_REG
        && q.bytes[7:4] != opdec_pkg::ESC_NIBBLE && q.bytes[15:12] != opdec_pkg::ESC_NIBBLE
        |-> src_loc_o == {4'h0, q.bytes[7:0]} && dst_loc_o == {4'h0, q.bytes[15:8]})
        else $error("add operand order wrong");

    // Escaped source uses the pointer bank
    chk_escaped_select: assert property (
        ops_valid_o && fmt_o == opdec_pkg::FMT_ADD_REG
        && q.bytes[7:4] == opdec_pkg::ESC_NIBBLE
        |-> src_loc_o == {$past(rp_i), q.bytes[3:0]})
        else $error("escaped register wrong");

    chk_bit_index: assert property (
        ops_valid_o && fmt_o == opdec_pkg::FMT_BIT
        |-> ops_o.bit_index == q.bytes[6:4])
        else $error("bit index wrong");

    chk_direct_addr: assert property (
        ops_valid_o && fmt_o == opdec_pkg::FMT_JUMP
        |-> ops_o.direct_address == {q.bytes[7:0], q.bytes[15:8]})
        else $error("direct address wrong");

    chk_far_locs: assert property (
        ops_valid_o && fmt_o == opdec_pkg::FMT_ADD_FAR
        |-> src_loc_o == {q.bytes[7:0], q.bytes[15:12]} && dst_loc_o == {q.bytes[11:8], q.bytes[23:16]})
        else $error("far locations wrong");

    chk_literal_byte: assert property (
        ops_valid_o && fmt_o == opdec_pkg::FMT_ADD_LIT
        |-> ops_o.literal_operand_byte == q.bytes[15:8])
        else $error("literal byte wrong");

    // Pairs never start on an odd register
    chk_pair_even: assert property (
        ops_valid_o && fmt_o == opdec_pkg::FMT_PAIR
        |-> !dst_loc_o[0] && !ops_o.working_pair[0] && !ops_o.register_pair[0]
            && ops_o.pair_is_working == (q.bytes[7:4] == opdec_pkg::ESC_NIBBLE))
        else $error("pair not even");

    chk_polarity: assert property (
        ops_valid_o && fmt_o == opdec_pkg::FMT_BIT
        |-> ops_o.polarity == q.bytes[7])
        else $error("polarity wrong");

    chk_branch_target: assert property (
        ops_valid_o && fmt_o == opdec_pkg::FMT_BRANCH
        |-> ops_o.branch_target == q.inst_addr + 16'h0002 + {{8{q.bytes[7]}}, q.bytes[7:0]})
        else $error("branch target wrong");

    chk_index_sum: assert property (
        ops_valid_o && fmt_o == opdec_pkg::FMT_INDEX
        |-> ops_o.indexed_location == $past(base_value_i) + {{8{q.bytes[15]}}, q.bytes[15:8]})
        else $error("indexed location wrong");

    chk_trap_vector: assert property (
        ops_valid_o && fmt_o == opdec_pkg::FMT_TRAP
        |-> ops_o.vector == q.bytes[7:0])
        else $error("vector wrong");

    // Add writes the sum exactly one cycle after the read
    chk_add_write: assert property (
        q.st == opdec_pkg::ST_ADD_READ && q.fmt == opdec_pkg::FMT_ADD_REG
        |=> write_en_o && write_loc_o == $past(dst_loc_o)
            && write_data_o == 8'($past(src_value_i) + $past(dst_value_i)))
        else $error("add result wrong");

    chk_add_spacing: assert property (
        ops_valid_o && is_add(fmt_o) |-> !write_en_o ##1 write_en_o ##1 !write_en_o)
        else $error("add write timing wrong");

    // First operand byte lands in the lowest slot
    chk_fetch_order: assert property (
        q.st == opdec_pkg::ST_OPERAND && byte_valid_i && q.count == 2'd0
        |=> q.bytes[7:0] == $past(byte_i))
        else $error("fetch order wrong");

    // Refused byte leaves the capture alone
    chk_refused_hold: assert property (
        byte_valid_i && !byte_ready_o
        |=> q.opcode == $past(q.opcode) && q.count == $past(q.count)
            && q.bytes == $past(q.bytes))
        else $error("refused byte taken");

    // Decode pulse is one cycle wide
    chk_valid_pulse: assert property (
        ops_valid_o |=> !ops_valid_o)
        else $error("decode pulse too long");

    // Pulse two edges after the last operand byte
    chk_decode_latency: assert property (
        q.st == opdec_pkg::ST_OPERAND && byte_valid_i
        && q.count + 2'h1 == opdec_pkg::operand_bytes(q.fmt)
        |-> ##2 ops_valid_o)
        else $error("decode latency wrong");

    // Unknown opcode fetches no operands
    chk_unknown_skip: assert property (
        q.st == opdec_pkg::ST_OPCODE && byte_valid_i
        && opcode_fmt(byte_i) == opdec_pkg::FMT_NONE
        |=> q.st == opdec_pkg::ST_OPCODE && !ops_valid_o)
        else $error("unknown opcode not skipped");

    // Literal add, carry dropped
    chk_literal_write: assert property (
        q.st == opdec_pkg::ST_ADD_READ && q.fmt == opdec_pkg::FMT_ADD_LIT
        |=> write_en_o && write_loc_o == $past(dst_loc_o)
            && write_data_o == 8'($past(dst_value_i) + $past(ops_o.literal_operand_byte)))
        else $error("literal add wrong");

    // Far add writes the 12-bit destination
    chk_far_write: assert property (
        q.st == opdec_pkg::ST_ADD_READ && q.fmt == opdec_pkg::FMT_ADD_FAR
        |=> write_en_o && write_loc_o == $past(dst_loc_o)
            && write_data_o == 8'($past(src_value_i) + $past(dst_value_i)))
        else $error("far add wrong");

    // Bit operand names a working register
    chk_bit_working: assert property (
        ops_valid_o && fmt_o == opdec_pkg::FMT_BIT
        |-> ops_o.working_register == q.bytes[3:0] && dst_loc_o == {$past(rp_i), q.bytes[3:0]})
        else $error("bit register wrong");

endmodule

`default_nettype wire

// ==== core/opdec_pkg.sv ====
`default_nettype none
package opdec_pkg;

    // ==========================================
    // Opcodes that carry operand fields
    localparam logic [7:0] OPC_ADD_REG = 8'h04;
    localparam logic [7:0] OPC_ADD_LIT = 8'h06;
    localparam logic [7:0] OPC_ADD_FAR = 8'h08;
    localparam logic [7:0] OPC_JUMP = 8'h8D;
    localparam logic [7:0] OPC_BRANCH = 8'h8B;
    localparam logic [7:0] OPC_TRAP = 8'hF2;
    localparam logic [7:0] OPC_BIT = 8'hE2;
    localparam logic [7:0] OPC_INC_PAIR = 8'hA0;
    localparam logic [7:0] OPC_LOAD_INDEX = 8'hC7;

    // ==========================================
    // Field layout
    localparam logic [3:0] ESC_NIBBLE = 4'hE;
    localparam int POL_POS = 7;
    localparam int BIT_IDX_LSB = 4;
    localparam int HI_NIB_LSB = 4;
    localparam logic [15:0] OPCODE_LEN = 16'h0001;

    // ==========================================
    // Operand formats and controller states
    typedef enum logic [3:0] {
        FMT_NONE,
        FMT_ADD_REG,
        FMT_ADD_LIT,
        FMT_ADD_FAR,
        FMT_JUMP,
        FMT_BRANCH,
        FMT_TRAP,
        FMT_BIT,
        FMT_PAIR,
        FMT_INDEX
    } fmt_t;

    typedef enum logic [2:0] {
        ST_OPCODE,
        ST_OPERAND,
        ST_DECODED,
        ST_ADD_READ,
        ST_ADD_WRITE
    } state_t;

    // Decoded operand classes
    typedef struct packed {
        logic [11:0] src_loc;
        logic [11:0] dst_loc;
        logic [7:0] literal_operand_byte;
        logic [15:0] direct_address;
        logic [15:0] branch_target;
        logic [2:0] bit_index;
        logic polarity;
        logic [3:0] working_register;
        logic [3:0] working_pair;
        logic [7:0] register_pair;
        logic pair_is_working;
        logic odd_pair;
        logic [15:0] indexed_location;
        logic [7:0] vector;
    } operand_t;

    // Whole controller state
    typedef struct packed {
        state_t st;
        logic [7:0] opcode;
        fmt_t fmt;
        logic [1:0] count;
        logic [23:0] bytes;
        logic [15:0] inst_addr;
        operand_t ops;
        logic ops_valid;
        logic wr_en;
        logic [11:0] wr_loc;
        logic [7:0] wr_data;
    } core_t;

    localparam core_t CORE_RESET = '0;

    // Operand bytes that follow each opcode
    function automatic logic [1:0] operand_bytes(input fmt_t f);
        case (f)
            FMT_ADD_REG, FMT_ADD_LIT, FMT_JUMP, FMT_INDEX: operand_bytes = 2'd2;
            FMT_ADD_FAR: operand_bytes = 2'd3;
            FMT_NONE: operand_bytes = 2'd0;
            default: operand_bytes = 2'd1;
        endcase
    endfunction

endpackage

`default_nettype wire

// ==== core/operand_extract.sv ====
`timescale 1ns/100ps
`default_nettype none

module operand_extract
(
    // Captured instruction
    input wire opdec_pkg::fmt_t fmt_i,
    input wire logic [23:0] bytes_i,
    input wire logic [15:0] inst_addr_i,
    // Context
    input wire logic [7:0] rp_i,
    input wire logic [15:0] base_value_i,
    // Result
    output var opdec_pkg::operand_t ops_o
);

    // ==========================================
    // Helpers
    // Escaped byte picks a working register in the pointer's bank
    function automatic logic [11:0] reg_loc(input logic [7:0] b, input logic [7:0] rp);
        if (b[7:4] == opdec_pkg::ESC_NIBBLE)
            reg_loc = {rp, b[3:0]};
        else
            reg_loc = {4'h0, b};
    endfunction

    function automatic logic [15:0] sext(input logic [7:0] b);
        sext = {{8{b[7]}}, b};
    endfunction

    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;

    assign b0 = bytes_i[7:0];
    assign b1 = bytes_i[15:8];
    assign b2 = bytes_i[23:16];

    // ==========================================
    // Field extraction per format
    always_comb
    begin
        ops_o = '0;
        case (fmt_i)
            opdec_pkg::FMT_ADD_REG:
            begin
                ops_o.src_loc = reg_loc(b0, rp_i);
                ops_o.dst_loc = reg_loc(b1, rp_i);
            end
            opdec_pkg::FMT_ADD_LIT:
            begin
                ops_o.dst_loc = reg_loc(b0, rp_i);
                ops_o.literal_operand_byte = b1;
            end
            opdec_pkg::FMT_ADD_FAR:
            begin
                ops_o.src_loc = {b0, b1[7:4]};
                ops_o.dst_loc = {b1[3:0], b2};
            end
            opdec_pkg::FMT_JUMP:
                ops_o.direct_address = {b0, b1};
            opdec_pkg::FMT_BRANCH:
                // Offset counts from the next instruction
                ops_o.branch_target = inst_addr_i + opdec_pkg::OPCODE_LEN
                    + {14'h0000, opdec_pkg::operand_bytes(fmt_i)} + sext(b0);
            opdec_pkg::FMT_TRAP:
                ops_o.vector = b0;
            opdec_pkg::FMT_BIT:
            begin
                ops_o.polarity = b0[opdec_pkg::POL_POS];
                ops_o.bit_index = b0[opdec_pkg::BIT_IDX_LSB +: 3];
                ops_o.working_register = b0[3:0];
                ops_o.dst_loc = {rp_i, b0[3:0]};
            end
            opdec_pkg::FMT_PAIR:
            begin
                // Odd low bit is flagged, never honoured
                ops_o.odd_pair = b0[0];
                if (b0[7:4] == opdec_pkg::ESC_NIBBLE)
                begin
                    ops_o.pair_is_working = 1'b1;
                    ops_o.working_pair = {b0[3:1], 1'b0};
                    ops_o.dst_loc = {rp_i, b0[3:1], 1'b0};
                end
                else
                begin
                    ops_o.register_pair = {b0[7:1], 1'b0};
                    ops_o.dst_loc = {4'h0, b0[7:1], 1'b0};
                end
            end
            opdec_pkg::FMT_INDEX:
            begin
                ops_o.dst_loc = {rp_i, b0[opdec_pkg::HI_NIB_LSB +: 4]};
                ops_o.src_loc = {rp_i, b0[3:0]};
                ops_o.indexed_location = base_value_i + sext(b1);
            end
            default:
                ops_o = '0;
        endcase
    end

endmodule

`default_nettype wire

// ==== bench/prog_mem_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Program memory and register file model
module prog_mem_model
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Byte stream
    input wire logic byte_ready_i,
    output logic byte_valid_o,
    output logic [7:0] byte_o,
    output logic [15:0] byte_addr_o,
    // Register file
    input wire logic [11:0] src_loc_i,
    input wire logic [11:0] dst_loc_i,
    input wire logic write_en_i,
    input wire logic [11:0] write_loc_i,
    input wire logic [7:0] write_data_i,
    output logic [7:0] src_value_o,
    output logic [7:0] dst_value_o
);
    logic [7:0] mem [0:255];
    logic [7:0] regs [0:4095];
    int wr_ptr = 0;
    int rd_ptr = 0;
    bit slow = 1'b0;
    bit gap = 1'b0;
    bit taken = 1'b0;

    // Queue one byte; code starts at 0100h
    task automatic put(input logic [7:0] b);
        mem[wr_ptr[7:0]] = b;
        wr_ptr++;
    endtask

    // Combinational read, as the core assumes
    assign src_value_o = regs[src_loc_i];
    assign dst_value_o = regs[dst_loc_i];

    // Hand-over and write-back on the rising edge
    always @(posedge clk_i)
    begin
        // Seen by the following falling edge
        taken <= byte_valid_o && byte_ready_i && !reset_i;
        if (byte_valid_o && byte_ready_i && !reset_i)
            rd_ptr <= rd_ptr + 1;
        if (write_en_i)
            regs[write_loc_i] <= write_data_i;
    end

    // Offer bytes in order; a slow memory leaves gaps, idle line toggles
    always @(negedge clk_i)
    begin
        gap <= ~gap;
        if (reset_i)
        begin
            byte_valid_o <= 1'b0;
            byte_o <= 8'h00;
            byte_addr_o <= 16'h0000;
        end
        else if (!byte_valid_o || taken)
        begin
            if (rd_ptr < wr_ptr && !(slow && gap))
            begin
                byte_valid_o <= 1'b1;
                byte_o <= mem[rd_ptr[7:0]];
                byte_addr_o <= 16'h0100 + rd_ptr[15:0];
            end
            else
            begin
                byte_valid_o <= 1'b0;
                byte_o <= ~byte_o;
                byte_addr_o <= ~byte_addr_o;
            end
        end
    end
endmodule

`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end

module tb_top;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] rp_i = 8'h00;
    logic byte_valid_i, byte_ready_o, ops_valid_o, write_en_o;
    logic [7:0] byte_i, opcode_o, src_value_i, dst_value_i, write_data_o;
    logic [15:0] byte_addr_i, base_value_i, op_addr;
    logic [11:0] base_loc_o, src_loc_o, dst_loc_o, write_loc_o;
    opdec_pkg::fmt_t fmt_o;
    opdec_pkg::operand_t ops_o;
    int err_total = 0;
    int tests_run = 0;

    // Indexed base register contents follow the named location
    assign base_value_i = {4'hA, base_loc_o};

    operand_decoder uut (.clk_i(clk_i), .reset_i(reset_i), .byte_valid_i(byte_valid_i),
        .byte_i(byte_i), .byte_addr_i(byte_addr_i), .byte_ready_o(byte_ready_o), .rp_i(rp_i),
        .base_value_i(base_value_i), .base_loc_o(base_loc_o), .ops_valid_o(ops_valid_o),
        .opcode_o(opcode_o), .fmt_o(fmt_o), .ops_o(ops_o), .src_loc_o(src_loc_o),
        .dst_loc_o(dst_loc_o), .src_value_i(src_value_i), .dst_value_i(dst_value_i),
        .write_en_o(write_en_o), .write_loc_o(write_loc_o), .write_data_o(write_data_o));

    prog_mem_model pm (.clk_i(clk_i), .reset_i(reset_i), .byte_ready_i(byte_ready_o),
        .byte_valid_o(byte_valid_i), .byte_o(byte_i), .byte_addr_o(byte_addr_i),
        .src_loc_i(src_loc_o), .dst_loc_i(dst_loc_o), .write_en_i(write_en_o),
        .write_loc_i(write_loc_o), .write_data_i(write_data_o), .src_value_o(src_value_i),
        .dst_value_o(dst_value_i));

    // ==========================================
    // Shared tasks
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Wait a bounded time for a decode pulse
    task automatic wait_decode(input logic [7:0] opc, input opdec_pkg::fmt_t f);
        int i;
        for (i = 0; i < 40; i++)
        begin
            @(posedge clk_i);
            #1;
            if (ops_valid_o === 1'b1)
                break;
        end
        `CHK("decode pulse", 1'b1, ops_valid_o)
        `CHK("opcode", opc, opcode_o)
        `CHK("format", f, fmt_o)
    endtask

    // Queue one instruction, then wait for its decode
    task automatic issue(input logic [7:0] opc, input opdec_pkg::fmt_t f, input logic [7:0] b0,
        input logic [7:0] b1, input logic [7:0] b2, input int n);
        op_addr = 16'h0100 + pm.wr_ptr[15:0];
        pm.put(opc);
        if (n > 0)
            pm.put(b0);
        if (n > 1)
            pm.put(b1);
        if (n > 2)
            pm.put(b2);
        wait_decode(opc, f);
    endtask

    // Write-back lands one cycle after the decode pulse, for one cycle
    task automatic check_write(input logic [11:0] loc, input logic [7:0] val);
        `CHK("early write", 1'b0, write_en_o)
        @(posedge clk_i);
        #1;
        `CHK("write pulse", 1'b1, write_en_o)
        `CHK("write loc", loc, write_loc_o)
        `CHK("write data", val, write_data_o)
        @(posedge clk_i);
        #1;
        `CHK("write ends", 1'b0, write_en_o)
    endtask

    // ==========================================
    // Scenarios
    task automatic t_add();
        @(negedge clk_i);
        rp_i = 8'h10;
        pm.regs[12'h108] = 8'h25;
        pm.regs[12'h043] = 8'hF0;
        pm.regs[12'h008] = 8'h07;
        issue(8'h04, opdec_pkg::FMT_ADD_REG, 8'hE8, 8'h43, 8'h00, 2);
        `CHK("escaped src", 12'h108, src_loc_o)
        `CHK("add dst", 12'h043, dst_loc_o)
        check_write(12'h043, 8'h15);
        issue(8'h04, opdec_pkg::FMT_ADD_REG, 8'h08, 8'h43, 8'h00, 2);
        `CHK("plain src", 12'h008, ops_o.src_loc)
        check_write(12'h043, 8'h1C);
        @(negedge clk_i);
        rp_i = 8'h20;
        pm.regs[12'h203] = 8'h01;
        issue(8'h06, opdec_pkg::FMT_ADD_LIT, 8'hE3, 8'hFF, 8'h00, 2);
        `CHK("literal", 8'hFF, ops_o.literal_operand_byte)
        check_write(12'h203, 8'h00);
        pm.regs[12'h234] = 8'h11;
        pm.regs[12'hFFF] = 8'h22;
        issue(8'h08, opdec_pkg::FMT_ADD_FAR, 8'h23, 8'h4F, 8'hFF, 3);
        `CHK("far src", 12'h234, src_loc_o)
        `CHK("far dst", 12'hFFF, dst_loc_o)
        // Next opcode must wait out the add
        pm.put(8'hF2);
        pm.put(8'hC3);
        check_write(12'hFFF, 8'h33);
        wait_decode(8'hF2, opdec_pkg::FMT_TRAP);
        `CHK("held vector", 8'hC3, ops_o.vector)
    endtask

    // Jump, branch and trap bounds, back to back
    task automatic t_flow();
        logic [15:0] a [3] = '{16'h0000, 16'hFFFF, 16'h1234};
        logic [7:0] v [3] = '{8'h7F, 8'h80, 8'h00};
        for (int i = 0; i < 3; i++)
        begin
            issue(8'h8D, opdec_pkg::FMT_JUMP, a[i][15:8], a[i][7:0], 8'h00, 2);
            `CHK("direct", a[i], ops_o.direct_address)
            issue(8'h8B, opdec_pkg::FMT_BRANCH, v[i], 8'h00, 8'h00, 1);
            `CHK("target", op_addr + 16'h0002 + {{8{v[i][7]}}, v[i]}, ops_o.branch_target)
            issue(8'hF2, opdec_pkg::FMT_TRAP, ~v[i], 8'h00, 8'h00, 1);
            `CHK("vector", ~v[i], ops_o.vector)
        end
    endtask

    // Every polarity and bit number
    task automatic t_bit();
        logic [7:0] b;
        for (int i = 0; i < 16; i++)
        begin
            b = {i[3:0], i[3:0]};
            issue(8'hE2, opdec_pkg::FMT_BIT, b, 8'h00, 8'h00, 1);
            `CHK("polarity", i[3], ops_o.polarity)
            `CHK("bit index", i[2:0], ops_o.bit_index)
            `CHK("working reg", i[3:0], ops_o.working_register)
        end
    endtask

    // Working and register pairs, even and odd
    task automatic t_pair();
        logic [7:0] t [6] = '{8'hE6, 8'hE7, 8'hEE, 8'hFE, 8'h00, 8'h41};
        logic w;
        for (int i = 0; i < 6; i++)
        begin
            w = (t[i][7:4] == 4'hE);
            issue(8'hA0, opdec_pkg::FMT_PAIR, t[i], 8'h00, 8'h00, 1);
            `CHK("pair kind", w, ops_o.pair_is_working)
            `CHK("odd pair", t[i][0], ops_o.odd_pair)
            if (w)
                `CHK("working pair", {t[i][3:1], 1'b0}, ops_o.working_pair)
            else
                `CHK("register pair", {t[i][7:1], 1'b0}, ops_o.register_pair)
        end
    endtask

    // Signed index both ways, then a skipped opcode on a slow memory
    task automatic t_index();
        @(negedge clk_i);
        rp_i = 8'h30;
        issue(8'hC7, opdec_pkg::FMT_INDEX, 8'h35, 8'h80, 8'h00, 2);
        `CHK("index down", 16'hA285, ops_o.indexed_location)
        issue(8'hC7, opdec_pkg::FMT_INDEX, 8'h35, 8'h7F, 8'h00, 2);
        `CHK("index up", 16'hA384, ops_o.indexed_location)
        pm.slow = 1'b1;
        pm.put(8'h00);
        issue(8'hF2, opdec_pkg::FMT_TRAP, 8'h5A, 8'h00, 8'h00, 1);
        `CHK("after skip", 8'h5A, ops_o.vector)
        pm.slow = 1'b0;
    endtask

    // Reset cuts a half-fetched jump
    task automatic t_reset();
        pm.put(8'h8D);
        pm.put(8'h12);
        repeat (4) @(negedge clk_i);
        reset_i = 1'b1;
        repeat (2) @(negedge clk_i);
        reset_i = 1'b0;
        `CHK("ready after cut", 1'b1, byte_ready_o)
        `CHK("opcode cleared", 8'h00, opcode_o)
        `CHK("ops cleared", 8'h00, ops_o.vector)
        issue(8'hF2, opdec_pkg::FMT_TRAP, 8'hA5, 8'h00, 8'h00, 1);
        `CHK("after cut", 8'hA5, ops_o.vector)
    endtask

    // ==========================================
    // Clock, watchdog and main sequence
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end

    // Whole run needs a few thousand cycles at most
    initial
    begin
        #200000;
        err_total++;
        $display("watchdog expired");
        print_verdict();
    end

    initial
    begin
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        reset_i = 1'b0;
        `CHK("ready after reset", 1'b1, byte_ready_o)
        `CHK("idle pulse", 1'b0, ops_valid_o)
        `CHK("idle write", 1'b0, write_en_o)
        t_add();
        t_flow();
        t_bit();
        t_pair();
        t_index();
        t_reset();
        print_verdict();
    end
endmodule

`default_nettype wire
